//--- hw/lps_pin_select.sv
// LCD pin function control register and the pin function decode that it drives.
//
// Overview of operation
// [R1] Byte register at H'C0, all bits read/write, cleared to zero on reset.
// [R2] Bits: duty[7:6], common mux[5], expansion[4], segment group select[3:0].
// [R3] Expansion and select all zero: all forty pins are port pins.
// [R4] Select n from 1 to 7 lights n+1 groups, filled from the top down.
// [R5] Select top bit set ignores middle bits; bit 0 picks nine or ten groups.
// [R6] Expansion bit set: pins 40-37 carry expansion signals, rest follow select.
// [R7] Duty selects static, 1/2, 1/3, 1/4; mux picks port or repeated commons.
// [R8] Unassigned pins stay ports; new settings act on the next clock after write.
`include "lps_defs.svh"

module lps_pin_select
    import lps_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wrData,
    input  wire logic        wrStrobe,
    input  wire logic        rdStrobe,
    output logic      [7:0]  rdData,
    output logic      [39:0] segmentOutputPin,
    output logic      [3:0]  expansionPin,
    output logic      [3:0]  commonActive,
    output logic      [3:0]  commonPort,
    output logic             common4NonSelect,
    output lps_duty_e        dutyMode
);

    // ****************************************************************
    // Register access
    // ****************************************************************
    // The slave never stalls the master: a write lands at the strobe's edge.
    // Reads are registered so that rdData comes straight from a flip-flop.
    // The price is one cycle of read latency, which the bus contract allows.
    // Only one address is decoded; the rest of the byte space is left unused.
    logic [7:0] ctrl_q;
    wire        hitCtrl = (addr == `LPS_CTRL_ADDR);
    wire        wrCtrl  = wrStrobe && hitCtrl;
    // Unmapped addresses read as zero so software sees a defined value.
    wire  [7:0] rdNext  = hitCtrl ? ctrl_q : 8'h00;

    // Control register; every bit is plain read/write.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_q <= `LPS_CTRL_RESET; // [R1]
        end else if (wrCtrl) begin
            ctrl_q <= wrData; // [R1]
        end
    end

    // Read data stands in the cycle after the strobe and only there.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdData <= 8'h00;
        end else begin
            rdData <= rdStrobe ? rdNext : 8'h00;
        end
    end

    // ****************************************************************
    // Pin function decode
    // ****************************************************************
    // The decode is purely combinational from the stored register.
    // Every pin function is then registered once, so a write reaches the pins
    // one clock after it lands, the same for every field.
    // Pins that are not segment or expansion stay with the ordinary port logic.
    wire [1:0] dutySel    = ctrl_q[`LPS_DUTY_MSB:`LPS_DUTY_LSB]; // [R2]
    wire       commonRep  = ctrl_q[`LPS_CMX_BIT]; // [R2]
    wire       expSel     = ctrl_q[`LPS_SGX_BIT]; // [R2]
    wire [3:0] groupSel   = ctrl_q[`LPS_SGS_MSB:`LPS_SGS_LSB]; // [R2]
    // Group count per select value. Any nonzero value below 8 lights one group more
    // than its value, so the lowest step already covers the top two groups; with the
    // top bit set the middle bits do not matter and bit 0 picks nine or ten groups.
    // The expansion bit does not shift the count: it only takes the top group away.
    wire [3:0] groupInc   = groupSel + 4'h1; // [R4]
    wire [3:0] groupLow   = (groupSel == 4'h0) ? 4'h0 : groupInc; // [R3] [R4]
    wire [3:0] groupHigh  = groupSel[0] ? 4'hA : 4'h9; // [R5]
    wire [3:0] groupCount = groupSel[3] ? groupHigh : groupLow; // [R4] [R5]

    // Group g (0 = pins 4..1, 9 = pins 40..37) is segment when it ranks in the top count.
    logic [9:0] segGroup;
    always_comb begin
        for (int g = 0; g < `LPS_GROUPS; g++) begin
            segGroup[g] = (4'(`LPS_GROUPS - g) <= groupCount); // [R3] [R4]
        end
    end

    // Pin p belongs to group p/4; the expansion bit masks the top four pins.
    // Masking here rather than in the count keeps the two fields independent.
    logic [39:0] segPinNext;
    always_comb begin
        for (int p = 0; p < `LPS_PINS; p++) begin
            segPinNext[p] = segGroup[p / 4] && !(expSel && (p >= 36)); // [R6] [R8]
        end
    end
    wire [3:0] expPinNext = expSel ? 4'hF : 4'h0; // [R6]

    // Commons in use and those left as ports, per duty and mux setting.
    wire [3:0] comUsed = (dutySel == 2'h0) ? 4'h1 : (dutySel == 2'h1) ? 4'h3 :
                         (dutySel == 2'h2) ? 4'h7 : 4'hF; // [R7]
    wire [3:0] comActNext  = commonRep ? 4'hF : comUsed; // [R7]
    wire       nonSelNext  = commonRep && (dutySel == 2'h2); // [R7]

    // Outputs are registered; a write shows on the pins one clock later.
    // Reset values match a cleared register: static duty, one common driving,
    // the other three commons free as ports and every shared pin a port.
    // Registering costs a cycle but keeps decode glitches off the pads.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            segmentOutputPin <= 40'h00_0000_0000;
            expansionPin     <= 4'h0;
            commonActive     <= 4'h1;
            commonPort       <= 4'hE;
            common4NonSelect <= 1'b0;
            dutyMode         <= LPS_DUTY_STATIC;
        end else begin
            segmentOutputPin <= segPinNext; // [R8]
            expansionPin     <= expPinNext;
            commonActive     <= comActNext;
            commonPort       <= ~comActNext; // [R7]
            common4NonSelect <= nonSelNext;
            dutyMode         <= lps_duty_e'(dutySel);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Each check looks one clock after its cause, two clocks after the write for a_write_effect, matching the output registers.
    // They watch only what this block drives.
    a_write_lands: assert property (@(posedge clock) disable iff (rst) // [R1]
        wrCtrl |=> ctrl_q == $past(wrData)) else $error("Control write not stored.");
    a_read_back: assert property (@(posedge clock) disable iff (rst) // [R1]
        rdStrobe && hitCtrl |=> rdData == $past(ctrl_q)) else $error("Read data wrong.");
    a_all_port: assert property (@(posedge clock) disable iff (rst) // [R3]
        (ctrl_q[4:0] == 5'h00) |=> segmentOutputPin == 40'h0) else $error("Pins not ports.");
    a_top_group: assert property (@(posedge clock) disable iff (rst) // [R4]
        (groupSel == 4'h1 && !expSel) |=> segmentOutputPin == 40'hFF_0000_0000)
        else $error("Top two groups not segment.");
    a_nine_groups: assert property (@(posedge clock) disable iff (rst) // [R5]
        (groupSel[3] && !groupSel[0] && !expSel) |=> segmentOutputPin == 40'hFF_FFFF_FFF0)
        else $error("Nine groups wrong.");
    a_exp_pins: assert property (@(posedge clock) disable iff (rst) // [R6]
        expSel |=> expansionPin == 4'hF && segmentOutputPin[39:36] == 4'h0)
        else $error("Expansion pins wrong.");
    a_third_nonsel: assert property (@(posedge clock) disable iff (rst) // [R7]
        (dutySel == 2'h2 && commonRep) |=> common4NonSelect && commonPort == 4'h0)
        else $error("Non-select common wrong.");
    a_write_effect: assert property (@(posedge clock) disable iff (rst) // [R8]
        wrCtrl ##1 !wrCtrl |=> expansionPin[0] == $past(wrData[4], 2))
        else $error("Write not effective next clock.");

    // ****************************************************************
    // Further checks
    // ****************************************************************
    // Read data is zero in every cycle not following a read strobe.
    a_read_idle: assert property (@(posedge clock) disable iff (rst) // [R1]
        !rdStrobe |=> rdData == 8'h00)
        else $error("Read data not zero when idle.");
    // Reads of unmapped addresses return zero.
    a_read_unmapped: assert property (@(posedge clock) disable iff (rst) // [R1]
        (rdStrobe && !hitCtrl) |=> rdData == 8'h00)
        else $error("Unmapped read not zero.");
    // Writes to other addresses leave the register alone.
    a_write_refused: assert property (@(posedge clock) disable iff (rst) // [R1]
        (wrStrobe && !hitCtrl) |=> $stable(ctrl_q))
        else $error("Unmapped write changed register.");
    // The duty field reaches the duty output one clock after the write.
    a_duty_field: assert property (@(posedge clock) disable iff (rst) // [R2]
        wrCtrl ##1 !wrCtrl |=> dutyMode == lps_duty_e'($past(wrData[7:6], 2)))
        else $error("Duty field not applied.");
    // A middle select value lights one group more than its value.
    a_six_groups: assert property (@(posedge clock) disable iff (rst) // [R4]
        (groupSel == 4'h5 && !expSel) |=> segmentOutputPin == 40'hFF_FFFF_0000)
        else $error("Six groups wrong.");
    // The last step below the top bit lights eight groups.
    a_eight_groups: assert property (@(posedge clock) disable iff (rst) // [R4]
        (groupSel == 4'h7 && !expSel) |=> segmentOutputPin == 40'hFF_FFFF_FF00)
        else $error("Eight groups wrong.");
    // Top bit and bit 0 set make every group a segment group.
    a_ten_groups: assert property (@(posedge clock) disable iff (rst) // [R5]
        (groupSel[3] && groupSel[0] && !expSel) |=> segmentOutputPin == 40'hFF_FFFF_FFFF)
        else $error("Ten groups wrong.");
    // Expansion clear keeps the expansion outputs low.
    a_exp_off: assert property (@(posedge clock) disable iff (rst) // [R6]
        !expSel |=> expansionPin == 4'h0)
        else $error("Expansion pins set without expansion.");
    // With expansion, the lowest select step leaves one segment group below it.
    a_exp_one: assert property (@(posedge clock) disable iff (rst) // [R6]
        (expSel && groupSel == 4'h1) |=> segmentOutputPin == 40'h0F_0000_0000)
        else $error("Expansion with one group wrong.");
    // With expansion and all groups selected, the nine lower groups are segments.
    a_exp_rest: assert property (@(posedge clock) disable iff (rst) // [R6]
        (expSel && groupSel[3] && groupSel[0]) |=> segmentOutputPin == 40'h0F_FFFF_FFFF)
        else $error("Expansion with all groups wrong.");
    // With expansion and nine groups, the lowest group stays a port.
    a_exp_nine: assert property (@(posedge clock) disable iff (rst) // [R6]
        (expSel && groupSel[3] && !groupSel[0]) |=> segmentOutputPin == 40'h0F_FFFF_FFF0)
        else $error("Expansion with nine groups wrong.");
    // Static duty without repeat drives one common and frees three.
    a_static_com: assert property (@(posedge clock) disable iff (rst) // [R7]
        (dutySel == 2'h0 && !commonRep) |=> commonActive == 4'h1 && commonPort == 4'hE)
        else $error("Static commons wrong.");
    // Half duty without repeat drives two commons.
    a_half_com: assert property (@(posedge clock) disable iff (rst) // [R7]
        (dutySel == 2'h1 && !commonRep) |=> commonActive == 4'h3 && commonPort == 4'hC)
        else $error("Half duty commons wrong.");
    // Repeat mode drives all four commons.
    a_mux_repeat: assert property (@(posedge clock) disable iff (rst) // [R7]
        commonRep |=> commonActive == 4'hF && commonPort == 4'h0)
        else $error("Repeated commons wrong.");
    // Quarter duty never shows the non-select waveform.
    a_quarter_sel: assert property (@(posedge clock) disable iff (rst) // [R7]
        (dutySel == 2'h3) |=> !common4NonSelect)
        else $error("Quarter duty non-select set.");

endmodule // lps_pin_select

//--- hw/lps_defs.svh
// Register offset, field positions, reset value and table sizes for the LCD pin select block.
`ifndef LPS_DEFS_SVH
`define LPS_DEFS_SVH
`define LPS_CTRL_ADDR      8'hC0
`define LPS_CTRL_RESET     8'h00
`define LPS_DUTY_MSB       7
`define LPS_DUTY_LSB       6
`define LPS_CMX_BIT        5
`define LPS_SGX_BIT        4
`define LPS_SGS_MSB        3
`define LPS_SGS_LSB        0
`define LPS_GROUPS         10
`define LPS_PINS           40
`endif

//--- hw/lps_pkg.sv
// Types shared by the LCD pin select block.
package lps_pkg;
    typedef enum logic [1:0] {
        LPS_DUTY_STATIC  = 2'h0,
        LPS_DUTY_HALF    = 2'h1,
        LPS_DUTY_THIRD   = 2'h2,
        LPS_DUTY_QUARTER = 2'h3
    } lps_duty_e;
endpackage

//--- verification/lps_pin_select_tb.sv
// Self-checking testbench for the LCD pin select block.
`include "lps_defs.svh"
module lps_pin_select_tb
    import lps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 0, rst = 1, wrStrobe = 0, rdStrobe = 0, common4NonSelect;
    logic [7:0]  addr = 8'h00, wrData = 8'h00, rdData, a;
    logic [39:0] segmentOutputPin;
    logic [3:0]  expansionPin, commonActive, commonPort;
    lps_duty_e   dutyMode;
    int          err_count = 0, checked = 0, seed = 32'hbbcb, i;
    lps_pin_select u_lps_pin_select (.clock(clock), .rst(rst), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .segmentOutputPin(segmentOutputPin),
        .expansionPin(expansionPin), .commonActive(commonActive), .commonPort(commonPort),
        .common4NonSelect(common4NonSelect), .dutyMode(dutyMode));
    // Free-running 40 MHz clock.
    initial forever #12.5 clock = ~clock;
    // ****************************************
    // Bus tasks and the reference model
    // ****************************************
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task give_verdict();
        if (err_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // A write is taken at the edge after the strobe is raised.
    task wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clock);
        addr <= ad; wrData <= d; wrStrobe <= 1'b1;
        @(posedge clock);
        wrStrobe <= 1'b0;
    endtask
    // Read data is sampled in the one cycle where it stands.
    task rd(input logic [7:0] ad);
        @(posedge clock);
        addr <= ad; rdStrobe <= 1'b1;
        @(posedge clock);
        rdStrobe <= 1'b0;
        #1;
    endtask
    // Groups fill from the top pins downward; expansion steals the top group.
    task chkPins(input logic [7:0] v);
        int n; logic [39:0] m; logic [3:0] act;
        n = v[3] ? 9 + v[0] : ((v[2:0] == 3'h0) ? 0 : v[2:0] + 1);
        m = '0;
        for (int g = 0; g < n; g++) m[39-4*g -: 4] = 4'hF;
        if (v[4]) m[39:36] = 4'h0;
        case (v[7:6])
            2'h0: act = 4'h1;
            2'h1: act = 4'h3;
            2'h2: act = 4'h7;
            default: act = 4'hF;
        endcase
        if (v[5]) act = 4'hF;
        chk(segmentOutputPin, m);
        chk(expansionPin, {4{v[4]}});
        chk({commonActive, commonPort, common4NonSelect, dutyMode}, {act, ~act, v[7:6] == 2'h2 && v[5], v[7:6]});
    endtask
    // Main sequence: every register value, then unmapped accesses, then a second reset.
    initial begin
        repeat (19) @(posedge clock);
        #1 chkPins(8'h00);
        chk(rdData, 8'h00);
        @(posedge clock) rst <= 1'b0;
        for (i = 0; i < 256; i++) begin
            wr(`LPS_CTRL_ADDR, i[7:0]);
            @(posedge clock) #1 chkPins(i[7:0]);
            rd(`LPS_CTRL_ADDR);
            chk(rdData, i[7:0]);
        end
        repeat (8) begin
            a = 8'($random(seed));
            if (a == `LPS_CTRL_ADDR) a = 8'hC1;
            wr(a, 8'($random(seed)));
            rd(a);
            chk(rdData, 8'h00);
            rd(`LPS_CTRL_ADDR);
            chk(rdData, 8'hFF);
            chkPins(8'hFF);
        end
        @(posedge clock) rst <= 1'b1;
        @(posedge clock) rst <= 1'b0;
        #1 chkPins(8'h00);
        rd(`LPS_CTRL_ADDR);
        chk(rdData, 8'h00);
        give_verdict();
    end
endmodule // lps_pin_select_tb
